// *** logic/axis_monitor_map.vh ***
// register offsets, fields, reset values and timing for the axis fault monitor
`ifndef AXIS_MONITOR_MAP_VH
`define AXIS_MONITOR_MAP_VH
`define N_AXES            4
`define POS_W             32
`define MASK_RESET        16'h010c
`define SEL_NONE          4'hf
`define SB_WARN           1
`define SB_HOLD           7
`define SB_TRIP           8
`define TICK_NS           1000
`define CLK_NS            4
`define TICK_CYCLES       (`TICK_NS / `CLK_NS)
`define A_CTRL            8'h00
`define A_STAT            8'h04
`define A_IRQ_STAT        8'h08
`define A_IRQ_MASK        8'h0c
`define A_SEL             8'h10
`define A_HOLD_RATE       8'h14
`define A_JOG_RATE        8'h18
`define A_MOVE_RATE       8'h1c
`define A_AX_BASE         8'h40
`define AX_STRIDE         8'h20
`define AXO_DEMAND        8'h00
`define AXO_MEASURED      8'h04
`define AXO_TRIP          8'h08
`define AXO_WARN          8'h0c
`define AXO_MASK          8'h10
`define AXO_STATE         8'h14
`define AXO_DEV           8'h18
`define AXO_MOVE          8'h1c
`endif

// *** logic/axis_deviation_check.v ***
// one axis: position deviation and warning/trip status bits
`default_nettype none
module axis_deviation_check (
   // clock and reset
   input  wire        i_ref_clk,
   input  wire        i_resetn,
   // servo cycle tick
   input  wire        i_tick,
   // positions and limits
   input  wire [31:0] i_demand_position,
   input  wire [31:0] i_measured_position,
   input  wire [31:0] i_deviation_trip_limit,
   input  wire [31:0] i_deviation_warn_range,
   // results
   output reg  [31:0] o_position_deviation,
   output reg         o_warn,
   output reg         o_trip
);
   wire signed [31:0] dev_d;  // demand minus measured
   wire        [31:0] mag;    // magnitude for comparisons
   assign dev_d = i_demand_position - i_measured_position;
   assign mag   = dev_d[31] ? (32'h0 - dev_d) : dev_d;

   // update once per servo cycle so all axes are sampled together
   always @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_position_deviation <= 32'h0;
         o_warn               <= 1'b0;
         o_trip               <= 1'b0;
      end else if (i_tick) begin
         o_position_deviation <= dev_d;
         o_warn <= (mag > i_deviation_warn_range);
         o_trip <= (mag > i_deviation_trip_limit);
      end
   end
endmodule // axis_deviation_check
`default_nettype wire

// *** logic/axis_fault_and_feedhold_monitor.v ***
// axis supervision: deviation checks, motion error, jog and feedhold over ahb-lite
//
// Overview of operation
// - each servo cycle, mask AND state flags error
// - error drops drive enable, sets fault, latches axis
// - error mask resets to 268
// - deviation over trip limit sets bit 8
// - deviation over warn range sets bit 1
// - input selectors 0..7, -1 means none
// - fast jog input picks move speed, else jog
// - jog and hold inputs are active low
// - hold asserted: hold speed, bit 7, move kept
// - hold released: programmed speed returns
// - hold ignores cam, geared and linked moves
// - hold rate non-negative, resets to zero
//
// Chosen here: the AHB-Lite register port and the register offsets.
`default_nettype none
`include "axis_monitor_map.vh"
module axis_fault_and_feedhold_monitor (
   // clock and reset
   input  wire        i_ref_clk,
   input  wire        i_resetn,
   // ahb-lite slave
   input  wire        i_hsel,
   input  wire [31:0] i_haddr,
   input  wire [1:0]  i_htrans,
   input  wire        i_hwrite,
   input  wire [2:0]  i_hsize,
   input  wire [31:0] i_hwdata,
   input  wire        i_hready,
   output wire [31:0] o_hrdata,
   output wire        o_hreadyout,
   output wire        o_hresp,
   // digital inputs from switches, active low
   input  wire [7:0]  i_inputs_n,
   // outputs to drive and planner
   output reg         o_drive_enable_switch,
   output reg         o_motion_fault,
   output reg  [1:0]  o_fault_axis,
   output reg  [31:0] o_jog_rate,
   output reg  [`N_AXES-1:0] o_hold_active,
   output reg  [`N_AXES*32-1:0] o_axis_rate,
   // interrupt
   output wire        o_irq
);
   localparam NA = `N_AXES;
   localparam [9:0] TICK_N = `TICK_CYCLES;
   // move kind codes in each axis move register
   localparam [1:0] MV_SPEED = 2'h0;
   // other kinds: cam, geared and linked moves ignore hold

   // servo tick generator
   // a free-running divider; every per axis check and the
   // motion error latch set only on its one-cycle strobe,
   // so all axes are judged on one common sample
   // hazard: bus writes between two ticks are not seen until
   // the next tick, so a new limit takes up to a servo cycle
   reg  [9:0] tick_cnt_q;  // cycles into servo period
   wire       tick;        // one-cycle servo cycle strobe
   assign tick = (tick_cnt_q == TICK_N - 10'h1);
   // counter wraps on the strobe itself, giving a period of
   // exactly TICK_N reference clocks
   always @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) tick_cnt_q <= 10'h0;
      else if (tick) tick_cnt_q <= 10'h0;
      else tick_cnt_q <= tick_cnt_q + 10'h1;
   end

   // software settings
   // positions are written by the planner and encoder side,
   // limits and masks by the configuring software; all of
   // them are plain words with no side effects on write
   // mask is 16 bits wide, upper bus bits are dropped
   reg  [31:0] demand_q   [0:NA-1];  // demand position
   reg  [31:0] measured_q [0:NA-1];  // measured position
   reg  [31:0] trip_q     [0:NA-1];  // deviation trip limit
   reg  [31:0] warn_q     [0:NA-1];  // deviation warn range
   reg  [15:0] mask_q     [0:NA-1];  // motion error mask
   reg  [33:0] move_q     [0:NA-1];  // move kind + programmed speed
   reg  [3:0]  fast_sel_q;           // fast jog input, f = none
   reg  [3:0]  hold_sel_q;           // hold input, f = none
   reg  [31:0] hold_rate_q;          // hold speed
   reg  [31:0] slow_jog_rate_q;      // jog speed when fast jog off
   reg  [31:0] move_rate_q;          // normal move speed
   reg  [2:0]  irq_stat_q;           // sticky: fault, hold on, hold off
   reg  [2:0]  irq_mask_q;           // interrupt enables
   reg         hold_prev_q;          // hold level last cycle

   // input selection, active low, -1 (f) and 8..e read as unassigned
   // declared ahead of the axis checks, which fold hold into
   // each state word; an unassigned selector never asserts
   wire fast_on;
   wire hold_on;
   assign fast_on = !fast_sel_q[3] && !i_inputs_n[fast_sel_q[2:0]];
   assign hold_on = !hold_sel_q[3] && !i_inputs_n[hold_sel_q[2:0]];

   // per axis deviation checks
   // one checker per axis, all stepped by the same tick; the
   // registered warn and trip bits make the error one tick late
   wire [31:0] dev_w  [0:NA-1];
   wire [NA-1:0] warn_w;
   wire [NA-1:0] trip_w;
   wire [15:0] state_w [0:NA-1];
   wire [NA-1:0] match_w;
   genvar g;
   generate
      for (g = 0; g < NA; g = g + 1) begin : g_ax
         axis_deviation_check u_chk (
            .i_ref_clk              (i_ref_clk),
            .i_resetn               (i_resetn),
            .i_tick                 (tick),
            .i_demand_position      (demand_q[g]),
            .i_measured_position    (measured_q[g]),
            .i_deviation_trip_limit (trip_q[g]),
            .i_deviation_warn_range (warn_q[g]),
            .o_position_deviation   (dev_w[g]),
            .o_warn                 (warn_w[g]),
            .o_trip                 (trip_w[g])
         );
         // axis state word: bit 1 warn, bit 7 hold, bit 8 trip
         assign state_w[g] = {7'h0, trip_w[g], hold_on & (move_q[g][33:32] == MV_SPEED),
                              5'h0, warn_w[g], 1'b0};
         // any masked state bit raises the error; the mask resets
         // with the trip bit set so a runaway axis always stops
         assign match_w[g] = |(mask_q[g] & state_w[g]);
      end
   endgenerate

   // lowest matching axis index
   // scanned from the top down so the lowest match is the
   // last one written; the latch below keeps it until cleared
   reg [1:0] first_ax;
   integer k;
   always @* begin
      first_ax = 2'h0;
      // no match leaves zero, which the latch then ignores
      for (k = NA - 1; k >= 0; k = k - 1)
         if (match_w[k]) first_ax = k[1:0];
   end

   // ahb-lite address phase capture
   // the slave never stalls: the address phase is latched
   // here and the access completes in the following cycle,
   // writes landing at the end of that data phase
   // only word accesses are supported; the size is ignored
   // an unmapped address reads zero and ignores writes
   reg        wr_q;    // pending write
   reg        rd_q;    // pending read
   reg [7:0]  addr_q;  // pending word address
   wire       take;
   assign take = i_hsel && i_hready && i_htrans[1];
   assign o_hreadyout = 1'b1;  // zero wait states
   assign o_hresp     = 1'b0;  // always okay
   always @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         wr_q   <= 1'b0;
         rd_q   <= 1'b0;
         addr_q <= 8'h0;
      end else begin
         // address captured every cycle; only the strobes qualify it
         wr_q   <= take && i_hwrite;
         rd_q   <= take && !i_hwrite;
         addr_q <= {i_haddr[7:2], 2'b00};
      end
   end

   // per axis address decode
   // each axis owns a 0x20 window above the global words;
   // addresses past the last axis fall through to zero
   // the window index picks the axis, the offset the word
   wire       ax_hit;
   wire [1:0] ax_idx;
   wire [7:0] ax_off;
   wire [7:0] ax_rel;
   assign ax_rel = addr_q - `A_AX_BASE;
   assign ax_hit = (addr_q >= `A_AX_BASE) && !ax_rel[7];  // no alias past the last axis
   assign ax_idx = ax_rel[6:5];
   assign ax_off = {3'h0, ax_rel[4:0]};

   // software writes and fault bookkeeping
   // writing one to bit 0 of the control word clears a latched
   // motion error; writing zero there has no effect
   wire clr_fault;
   assign clr_fault = wr_q && (addr_q == `A_CTRL) && i_hwdata[0];
   integer a;
   always @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         for (a = 0; a < NA; a = a + 1) begin
            demand_q[a]   <= 32'h0;
            measured_q[a] <= 32'h0;
            trip_q[a]     <= 32'h0;
            warn_q[a]     <= 32'h0;
            mask_q[a]     <= `MASK_RESET;
            move_q[a]     <= 34'h0;
         end
         fast_sel_q      <= `SEL_NONE;
         hold_sel_q      <= `SEL_NONE;
         hold_rate_q     <= 32'h0;
         slow_jog_rate_q <= 32'h0;
         move_rate_q     <= 32'h0;
         irq_mask_q      <= 3'h0;
      end else if (wr_q) begin
         // writes are applied at the end of the data phase, when
         // the write data is valid on the bus
         if (ax_hit) begin
            case (ax_off)
               `AXO_DEMAND:   demand_q[ax_idx]   <= i_hwdata;
               `AXO_MEASURED: measured_q[ax_idx] <= i_hwdata;
               `AXO_TRIP:     trip_q[ax_idx]     <= i_hwdata;
               `AXO_WARN:     warn_q[ax_idx]     <= i_hwdata;
               `AXO_MASK:     mask_q[ax_idx]     <= i_hwdata[15:0];
               // move word: kind in the top two bits, speed below
               `AXO_MOVE:     move_q[ax_idx]     <= {i_hwdata[31:30], 2'b00, i_hwdata[29:0]};
               default:       ;  // read-only or unused
            endcase
         end else begin
            case (addr_q)
               // selectors keep all four bits so that -1 (f) can be
               // written back to unassign an input
               `A_SEL: begin
                  fast_sel_q <= i_hwdata[3:0];
                  hold_sel_q <= i_hwdata[11:8];
               end
               // a negative hold rate clamps to zero; jog and move rates are taken as written
               `A_HOLD_RATE: hold_rate_q <= i_hwdata[31] ? 32'h0 : i_hwdata;
               `A_JOG_RATE:  slow_jog_rate_q <= i_hwdata;
               `A_MOVE_RATE: move_rate_q <= i_hwdata;
               `A_IRQ_MASK:  irq_mask_q <= i_hwdata[2:0];
               default:      ;
            endcase
         end
      end
   end

   // motion error: drive off, fault set, first axis held until cleared
   // the drive enable defaults on after reset; it only ever
   // drops here, so the drive stays off until software clears
   // the fault; a cause still present drops it at the next tick
   // a clear that lands with a fresh match loses; a clear between
   // ticks drops a fault still present until the next tick sets it again
   always @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         // drive enabled and no fault out of reset
         o_drive_enable_switch <= 1'b1;
         o_motion_fault        <= 1'b0;
         o_fault_axis          <= 2'h0;
      end else if (tick && |match_w && !o_motion_fault) begin
         o_drive_enable_switch <= 1'b0;
         o_motion_fault        <= 1'b1;
         o_fault_axis          <= first_ax;
      end else if (clr_fault && !(tick && |match_w)) begin
         // a new match in the clear cycle keeps the fault
         o_drive_enable_switch <= 1'b1;
         o_motion_fault        <= 1'b0;
      end
   end

   // jog rate and per axis move rate
   // hold swaps the speed of speed moves only; the programmed
   // speed stays in its register, so release restores it
   // without software help
   // limitation: an idle axis of speed kind also shows hold
   // rates are registered, one cycle behind the inputs
   integer m;
   always @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_jog_rate    <= 32'h0;
         o_hold_active <= {NA{1'b0}};
         o_axis_rate   <= {NA*32{1'b0}};
         hold_prev_q   <= 1'b0;
      end else begin
         // fast jog pressed: normal move speed, else jog speed
         o_jog_rate  <= fast_on ? move_rate_q : slow_jog_rate_q;
         hold_prev_q <= hold_on;
         for (m = 0; m < NA; m = m + 1) begin
            // non speed moves keep their own rate
            if (hold_on && move_q[m][33:32] == MV_SPEED) begin
               o_hold_active[m] <= 1'b1;
               o_axis_rate[m*32 +: 32] <= hold_rate_q;
            end else begin
               o_hold_active[m] <= 1'b0;
               o_axis_rate[m*32 +: 32] <= move_q[m][31:0];
            end
         end
      end
   end

   // sticky events; set beats write-one clear
   // bit 0 motion error, bit 1 hold pressed, bit 2 hold let go;
   // an event in the clearing cycle is kept so none is missed
   wire [2:0] ev;
   assign ev = {hold_prev_q & ~hold_on, hold_on & ~hold_prev_q,
                tick & |match_w & ~o_motion_fault};
   always @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) irq_stat_q <= 3'h0;
      else if (wr_q && addr_q == `A_IRQ_STAT)
         irq_stat_q <= (irq_stat_q & ~i_hwdata[2:0]) | ev;
      else irq_stat_q <= irq_stat_q | ev;
   end
   // level output: stays high until software clears or masks
   assign o_irq = |(irq_stat_q & irq_mask_q);

   // read mux
   // pure decode of the latched address; the data phase gate
   // below holds the bus at zero outside a read so that idle
   // cycles never show stale register contents
   // reserved bits read as zero
   reg [31:0] rdata;
   always @* begin
      rdata = 32'h0;
      if (ax_hit) begin
         case (ax_off)
            `AXO_DEMAND:   rdata = demand_q[ax_idx];
            `AXO_MEASURED: rdata = measured_q[ax_idx];
            `AXO_TRIP:     rdata = trip_q[ax_idx];
            `AXO_WARN:     rdata = warn_q[ax_idx];
            `AXO_MASK:     rdata = {16'h0, mask_q[ax_idx]};
            `AXO_STATE:    rdata = {16'h0, state_w[ax_idx]};
            `AXO_DEV:      rdata = dev_w[ax_idx];
            `AXO_MOVE:     rdata = {move_q[ax_idx][33:32], move_q[ax_idx][29:0]};
            default:       rdata = 32'h0;
         endcase
      end else begin
         case (addr_q)
            `A_CTRL:      rdata = 32'h0;
            // status: axis, fast jog, hold, drive on, fault
            `A_STAT:      rdata = {26'h0, o_fault_axis, fast_on, hold_on,
                                   o_drive_enable_switch, o_motion_fault};
            `A_IRQ_STAT:  rdata = {29'h0, irq_stat_q};
            `A_IRQ_MASK:  rdata = {29'h0, irq_mask_q};
            `A_SEL:       rdata = {20'h0, hold_sel_q, 4'h0, fast_sel_q};
            `A_HOLD_RATE: rdata = hold_rate_q;
            `A_JOG_RATE:  rdata = slow_jog_rate_q;
            `A_MOVE_RATE: rdata = move_rate_q;
            default:      rdata = 32'h0;
         endcase
      end
   end
   // read data stands only in the data phase of a read
   assign o_hrdata = rd_q ? rdata : 32'h0;
endmodule // axis_fault_and_feedhold_monitor
`default_nettype wire

// *** tb/axis_monitor_sva.sv ***
// port assertions for the axis fault and feedhold monitor
`default_nettype none
`include "axis_monitor_map.vh"
module axis_monitor_sva (
   // clock and reset
   input wire logic                i_ref_clk,
   input wire logic                i_resetn,
   // bus side
   input wire logic                i_hsel,
   input wire logic [31:0]         i_haddr,
   input wire logic [1:0]          i_htrans,
   input wire logic                i_hwrite,
   input wire logic [31:0]         i_hwdata,
   input wire logic                i_hready,
   input wire logic [31:0]         o_hrdata,
   input wire logic                o_hreadyout,
   input wire logic                o_hresp,
   // switches and results
   input wire logic [7:0]          i_inputs_n,
   input wire logic                o_drive_enable_switch,
   input wire logic                o_motion_fault,
   input wire logic [1:0]          o_fault_axis,
   input wire logic [`N_AXES-1:0]  o_hold_active,
   input wire logic                o_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);
   wire       take;      // address phase accepted
   logic [8:0] idle_q;   // cycles with every switch open
   assign take = i_hsel && i_htrans[1] && i_hready;
   // count open-switch time; hold follows one cycle behind
   always @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn)
         idle_q <= 9'h000;
      else if (i_inputs_n != 8'hff)
         idle_q <= 9'h000;
      else if (idle_q != 9'h1ff)
         idle_q <= idle_q + 9'h001;
   end
   ready_okay_a: assert property (o_hreadyout && !o_hresp)
      else $error("slave not ready or not okay");
   drive_off_a: assert property (o_motion_fault |-> !o_drive_enable_switch)
      else $error("drive enabled during fault");
   axis_kept_a: assert property ($past(o_motion_fault) && o_motion_fault |-> $stable(o_fault_axis))
      else $error("fault axis moved while latched");
   clear_cause_a: assert property ($fell(o_motion_fault) |->
      $past(i_hwdata[0]) && $past(take && i_hwrite && i_haddr == 32'h0, 2))
      else $error("fault cleared without control write");
   hole_zero_a: assert property (take && !i_hwrite && i_haddr == 32'h3c |=> o_hrdata == 32'h0)
      else $error("unmapped read not zero");
   rdata_idle_a: assert property (!$past(take) |-> o_hrdata == 32'h0)
      else $error("read data outside data phase");
   hold_lag_a: assert property (|o_hold_active |-> idle_q == 9'h000)
      else $error("hold applied with switches open");
   reenable_a: assert property ($rose(o_drive_enable_switch) |-> !o_motion_fault)
      else $error("drive back on during fault");
   fault_seen_c: cover property ($rose(o_motion_fault));
   hold_seen_c: cover property (|o_hold_active);
   irq_seen_c: cover property ($rose(o_irq));
endmodule // axis_monitor_sva
bind axis_fault_and_feedhold_monitor axis_monitor_sva i_sva (
   .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_hsel(i_hsel), .i_haddr(i_haddr),
   .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
   .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
   .i_inputs_n(i_inputs_n), .o_drive_enable_switch(o_drive_enable_switch),
   .o_motion_fault(o_motion_fault), .o_fault_axis(o_fault_axis),
   .o_hold_active(o_hold_active), .o_irq(o_irq));
`default_nettype wire

// *** tb/switch_panel.sv ***
// switch panel model: jog and hold switches wired active low
`default_nettype none
module switch_panel (
   // switches held down, one bit each
   input  wire logic [7:0] i_pressed,
   // contacts seen by the monitor
   output logic [7:0]      o_inputs_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // a closed contact pulls its line to ground
   assign o_inputs_n = ~i_pressed;
endmodule // switch_panel
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the axis fault and feedhold monitor
`default_nettype none
`include "axis_monitor_map.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk;                 // reference clock
   logic        rstn = 1'b0;         // active-low reset
   logic        hsel = 1'b0;         // bus select
   logic [1:0]  htrans = 2'b00;      // transfer kind
   logic        hwrite = 1'b0;       // write strobe
   logic [31:0] haddr = 32'h0;       // byte address
   logic [31:0] hwdata = 32'h0;      // write data
   logic [7:0]  pressed = 8'h00;     // switches held down
   logic        rd_q = 1'b0;         // read data phase pending
   logic        ob_v = 1'b0;         // port sample pending
   logic [31:0] obs = 32'h0;         // port sample
   logic [31:0] lfsr = 32'h000143b2; // random source
   logic [31:0] exp_q[$];            // expected results, oldest first
   int          err_total = 0;
   int          checks = 0;
   wire  [7:0]  inputs_n;
   wire  [31:0] hrdata, jog_rate;
   wire         hready, hresp, drv_en, fault, irq;
   wire  [1:0]  fault_axis;
   wire  [3:0]  hold_act;
   wire  [127:0] axis_rate;
   axis_fault_and_feedhold_monitor i_axis_fault_and_feedhold_monitor (
      .i_ref_clk(clk), .i_resetn(rstn), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hready),
      .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_inputs_n(inputs_n),
      .o_drive_enable_switch(drv_en), .o_motion_fault(fault), .o_fault_axis(fault_axis),
      .o_jog_rate(jog_rate), .o_hold_active(hold_act), .o_axis_rate(axis_rate), .o_irq(irq));
   switch_panel i_switch_panel (.i_pressed(pressed), .o_inputs_n(inputs_n));
   // free-running clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic give_verdict;
      if (err_total == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // wait for ready under a bound; a hang ends the run
   task automatic wt;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 40);
      if (hready !== 1'b1) begin
         err_total++;
         $display("mismatch %0t bus hung", $time);
         give_verdict;
      end
   endtask
   // one single-word transfer; a read notes d as its expected word
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0, a};
      wt;
      htrans <= 2'b00;
      hwdata <= d;
      rd_q <= !w;
      if (!w)
         exp_q.push_back(d);
      wt;
      rd_q <= 1'b0;
   endtask
   // wait n cycles, then let the edge settle
   task automatic tk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // hand a settled port value to the watcher
   task automatic pc(input logic [31:0] o, input logic [31:0] e);
      exp_q.push_back(e);
      obs = o;
      ob_v = 1'b1;
      tk(1);
      ob_v = 1'b0;
   endtask
   // press switches at an edge, then allow a servo tick
   task automatic sw(input logic [7:0] v);
      @(posedge clk);
      pressed <= v;
      tk(300);
   endtask
   function automatic logic [7:0] ax(input int n, input logic [7:0] o);
      return `A_AX_BASE + 8'(n) * `AX_STRIDE + o;
   endfunction
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // watcher: each result meets the oldest note
   always @(posedge clk) begin
      if ((rd_q && hready) || ob_v) begin
         checks++;
         if (exp_q.size() == 0 || (rd_q ? hrdata : obs) !== exp_q[0]) begin
            err_total++;
            $display("mismatch %0t got %h", $time, rd_q ? hrdata : obs);
         end
         if (exp_q.size() != 0)
            void'(exp_q.pop_front());
      end
   end
   // main sequence
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      bus(0, ax(0, `AXO_MASK), 32'h10c);
      bus(0, `A_HOLD_RATE, 32'h0);
      bus(0, `A_SEL, 32'hf0f);
      bus(0, 8'h3c, 32'h0);
      // axis 1 inside the warning band only
      lfsr = nx(lfsr);
      bus(1, ax(1, `AXO_WARN), 32'h32);
      bus(1, ax(1, `AXO_TRIP), 32'h3e8);
      bus(1, ax(1, `AXO_MEASURED), {16'h0, lfsr[15:0]});
      bus(1, ax(1, `AXO_DEMAND), {16'h0, lfsr[15:0]} + 32'h3c);
      tk(600);
      bus(0, ax(1, `AXO_DEV), 32'h3c);
      bus(0, ax(1, `AXO_STATE), 32'h2);
      bus(0, `A_STAT, 32'h2);
      // fast jog on input 3, hold on input 5
      bus(1, `A_SEL, 32'h503);
      bus(0, `A_SEL, 32'h503);
      bus(1, `A_MOVE_RATE, 32'h1234);
      bus(1, `A_JOG_RATE, 32'h55);
      tk(300);
      pc(jog_rate, 32'h55);
      sw(8'h08);
      pc(jog_rate, 32'h1234);
      bus(0, `A_STAT, 32'ha);
      sw(8'h00);
      // hold: speed move slowed, linked move untouched
      bus(1, `A_HOLD_RATE, 32'hfffffff0);
      bus(0, `A_HOLD_RATE, 32'h0);
      bus(1, `A_HOLD_RATE, 32'h7);
      bus(1, ax(0, `AXO_MOVE), 32'h1f4);
      bus(1, ax(1, `AXO_MOVE), 32'h40000258);
      tk(300);
      pc(axis_rate[31:0], 32'h1f4);
      sw(8'h20);
      pc(axis_rate[31:0], 32'h7);
      pc({2'b00, axis_rate[61:32]}, 32'h258);
      pc({28'h0, hold_act}, 32'hd);
      bus(0, ax(0, `AXO_STATE), 32'h80);
      sw(8'h00);
      pc(axis_rate[31:0], 32'h1f4);
      // hold events are masked, then cleared
      pc({31'h0, irq}, 32'h0);
      bus(0, `A_IRQ_STAT, 32'h6);
      bus(1, `A_IRQ_STAT, 32'h7);
      bus(0, `A_IRQ_STAT, 32'h0);
      bus(1, `A_IRQ_MASK, 32'h1);
      // axes 2 and 3 trip together; the lower index wins
      bus(1, ax(2, `AXO_MASK), 32'h100);
      for (int n = 2; n < 4; n++)
         bus(1, ax(n, `AXO_TRIP), 32'ha);
      for (int n = 2; n < 4; n++)
         bus(1, ax(n, `AXO_DEMAND), 32'h64);
      tk(600);
      pc({29'h0, fault, drv_en, irq}, 32'h5);
      pc({30'h0, fault_axis}, 32'h2);
      bus(0, ax(2, `AXO_STATE), 32'h102);
      bus(0, `A_STAT, 32'h21);
      bus(1, `A_IRQ_STAT, 32'h1);
      tk(2);
      pc({31'h0, irq}, 32'h0);
      for (int n = 2; n < 4; n++)
         bus(1, ax(n, `AXO_DEMAND), 32'h0);
      tk(600);
      pc({30'h0, fault_axis}, 32'h2);
      bus(1, `A_CTRL, 32'h1);
      tk(2);
      pc({30'h0, fault, drv_en}, 32'h1);
      give_verdict;
   end
endmodule // tb_top
`default_nettype wire
